// ===== rtl/ccr_charge_counter_readout.sv
// charge counter readout: two counters with high/low byte registers and shadowing
`default_nettype none
module ccr_charge_counter_readout #(
	parameter int CNT_W   = ccr_pkg::CCR_CNT_W,   // counter width
	parameter int PRESC_W = ccr_pkg::CCR_PRESC_W  // prescaler setting width
) (
	// clock, reset, enable
	input  wire logic                          mclk,
	input  wire logic                          rst_b,
	input  wire logic                          clk_en,
	// register port from the serial control engine
	input  wire logic [7:0]                    reg_addr,
	input  wire logic                          reg_sel,
	input  wire logic                          reg_rd,
	output var  logic [ccr_pkg::CCR_BYTE_W-1:0] rd_data,
	output var  logic                          rd_valid,
	// converter pulses and the calibration clock, asynchronous
	input  wire logic                          buck_pulse,
	input  wire logic                          linreg_pulse,
	input  wire logic                          osc10_clk,
	// mode and control levels from logic on mclk
	input  wire logic                          deep_sleep_state,
	input  wire logic                          linear_regulator_standalone,
	input  wire logic                          calib_active,
	input  wire logic                          counter_clear_event,
	input  wire logic [PRESC_W-1:0]            counter_prescaler,
	// live state
	output var  logic                          calib_result_held
);
	import ccr_pkg::*;

	// width of a pulse group accumulator; a group of 2**presc pulses must fit in it
	localparam int PRE_W = 1 << PRESC_W;

	// ==========================================================
	// state
	// everything the block remembers sits in one struct, so one clock enable
	// and one reset branch cover all of it, the sync chains included
	typedef struct packed {
		logic [CCR_IN_N-1:0][CCR_SYNC_N-1:0] sync;      // synchroniser chains
		logic [CCR_IN_N-1:0]                 filt;      // agreed levels
		logic [CNT_W-1:0]                    buck_cnt;  // buck deep-sleep count
		logic [CNT_W-1:0]                    lin_cnt;   // linreg count or calib count
		logic [(1<<PRESC_W)-1:0]             buck_pre;  // pulse group accumulators
		logic [(1<<PRESC_W)-1:0]             lin_pre;
		logic [7:0]                          buck_shd;  // low byte shadows
		logic [7:0]                          lin_shd;
		logic                                cal_prev;  // calib level last cycle
		logic                                cal_held;  // calibration result pending
		logic [7:0]                          rd_data;
		logic                                rd_valid;
	} ccr_state_t;

	ccr_state_t st_reg;   // registered state
	ccr_state_t st_next;  // next state

	// ==========================================================
	// helpers
	// a prescaler setting of n means one count per 2**n converter pulses;
	// changing the setting mid-group is tolerated: a group already past the
	// new limit closes on its next pulse rather than wrapping round
	// true when a pulse completes a group of 2**presc pulses
	function automatic logic ccr_group_done(input logic [(1<<PRESC_W)-1:0] acc,
	                                        input logic [PRESC_W-1:0]       presc);
		logic [(1<<PRESC_W)-1:0] lim;
		lim = '0;
		lim = PRE_W'((1 << presc) - 1);
		return acc >= lim;
	endfunction

	// bump the group accumulator, returning a carry when the group closes
	function automatic logic [(1<<PRESC_W):0] ccr_group_step(
		input logic [(1<<PRESC_W)-1:0] acc,
		input logic [PRESC_W-1:0]       presc);
		logic [(1<<PRESC_W):0] res;
		res = '0;
		if (ccr_group_done(acc, presc)) begin
			res = {1'b1, {(1<<PRESC_W){1'b0}}};
		end else begin
			res = {1'b0, acc + 1'b1};
		end
		return res;
	endfunction

	// ==========================================================
	// next-state logic
	// one pass works out sync, edge detection, counting, calibration, clear
	// and the read port; later assignments win, so the clear overrides any
	// count made in the same cycle and a read always sees the registered
	// counter value, never a count that lands on the same edge
	always_comb begin
		logic [CCR_IN_N-1:0]     rise;       // clean rising edges
		logic                    buck_hold;  // buck pair addressed
		logic                    lin_hold;   // linreg pair addressed
		logic [(1<<PRESC_W):0]   step;
		rise      = '0;
		buck_hold = 1'b0;
		lin_hold  = 1'b0;
		step      = '0;
		st_next   = st_reg;
		st_next.rd_valid = 1'b0;
		// the pulses and the calibration clock come from other domains; a
		// stage-one glitch never reaches the counters because two later
		// stages must agree before the filtered level moves
		// three-stage sync; a level counts once stages two and three agree
		for (int i = 0; i < CCR_IN_N; i++) begin
			st_next.sync[i] = {st_reg.sync[i][CCR_SYNC_N-2:0],
			                   (i == CCR_IN_BUCK) ? buck_pulse :
			                   (i == CCR_IN_LDO)  ? linreg_pulse : osc10_clk};
			if (st_reg.sync[i][1] == st_reg.sync[i][2]) begin
				st_next.filt[i] = st_reg.sync[i][2];
			end
			rise[i] = st_next.filt[i] & ~st_reg.filt[i];
		end
		// counts missed while the pair is addressed are simply dropped
		buck_hold = reg_sel && (reg_addr == CCR_BUCK_SLEEP_CHARGE_HIGH ||
		                        reg_addr == CCR_BUCK_SLEEP_CHARGE_LOW);
		lin_hold  = reg_sel && (reg_addr == CCR_LINREG_CHARGE_HIGH ||
		                        reg_addr == CCR_LINREG_CHARGE_LOW);
		// buck counter: only in the deep-sleep state, in pulse groups
		if (rise[CCR_IN_BUCK] && deep_sleep_state && !buck_hold) begin
			step = ccr_group_step(st_reg.buck_pre, counter_prescaler);
			st_next.buck_pre = step[(1<<PRESC_W)-1:0];
			if (step[1<<PRESC_W]) begin
				st_next.buck_cnt = st_reg.buck_cnt + 1'b1;
			end
		end
		// the rising edge of the calibration window restarts the linreg count;
		// a host that wants the old pfm count must read it first, since
		// nothing here keeps a copy
		// linreg counter: 10 MHz cycles during calibration
		st_next.cal_prev = calib_active;
		if (calib_active && !st_reg.cal_prev) begin
			// calibration overwrites whatever count was there
			st_next.lin_cnt  = '0;
			st_next.lin_pre  = '0;
			st_next.cal_held = 1'b1;
		end else if (calib_active) begin
			if (rise[CCR_IN_OSC] && !lin_hold) begin
				st_next.lin_cnt = st_reg.lin_cnt + 1'b1;
			end
		end else if (!st_reg.cal_held) begin
			// standalone pfm counting; frozen while a result is held
			if (rise[CCR_IN_LDO] && linear_regulator_standalone && !lin_hold) begin
				step = ccr_group_step(st_reg.lin_pre, counter_prescaler);
				st_next.lin_pre = step[(1<<PRESC_W)-1:0];
				if (step[1<<PRESC_W]) begin
					st_next.lin_cnt = st_reg.lin_cnt + 1'b1;
				end
			end
		end
		// a clear that arrives while calibration runs is ignored, so a result
		// can never be wiped half-way through its measurement
		// clear event ends the held result and zeroes both counters
		if (counter_clear_event && !calib_active) begin
			st_next.buck_cnt = CNT_W'(CCR_CNT_RST);
			st_next.lin_cnt  = CNT_W'(CCR_CNT_RST);
			st_next.buck_pre = '0;
			st_next.lin_pre  = '0;
			st_next.cal_held = 1'b0;
		end
		// register reads: the answer is registered and stands until the next
		// read; rd_valid marks the one cycle after the read was taken, and an
		// address outside the four counter bytes answers a constant
		// register reads
		if (reg_rd) begin
			st_next.rd_valid = 1'b1;
			unique case (reg_addr)
				CCR_BUCK_SLEEP_CHARGE_HIGH: begin
					st_next.rd_data  = st_reg.buck_cnt[15:8];
					st_next.buck_shd = st_reg.buck_cnt[7:0];
				end
				CCR_BUCK_SLEEP_CHARGE_LOW: begin
					st_next.rd_data = st_reg.buck_shd;
				end
				CCR_LINREG_CHARGE_HIGH: begin
					st_next.rd_data = st_reg.lin_cnt[15:8];
					st_next.lin_shd = st_reg.lin_cnt[7:0];
				end
				CCR_LINREG_CHARGE_LOW: begin
					st_next.rd_data = st_reg.lin_shd;
				end
				default: begin
					// unmapped here: answers zero
					st_next.rd_data = CCR_UNMAPPED;
				end
			endcase
		end
	end

	// ==========================================================
	// a low clock enable holds the sync chains too, so a pulse seen while frozen is lost
	// state register; clock enable freezes everything
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			// only constants here: the whole struct clears, then the byte
			// registers take their reset value
			st_reg          <= '0;
			st_reg.rd_data  <= CCR_BYTE_RST;
			st_reg.buck_shd <= CCR_BYTE_RST;
			st_reg.lin_shd  <= CCR_BYTE_RST;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// outputs straight from flops
	// no logic between the state register and the pins, so the serial
	// engine sees clean levels one full cycle after each read
	assign rd_data           = st_reg.rd_data;
	assign rd_valid          = st_reg.rd_valid;
	assign calib_result_held = st_reg.cal_held;
endmodule
`default_nettype wire

// ===== rtl/ccr_pkg.sv
// package: register offsets, reset values and widths for the charge counter readout
`default_nettype none
package ccr_pkg;
	// ==========================================================
	// register offsets (byte address on the serial control port)
	localparam logic [7:0] CCR_BUCK_SLEEP_CHARGE_HIGH = 8'h17;
	localparam logic [7:0] CCR_BUCK_SLEEP_CHARGE_LOW  = 8'h18;
	localparam logic [7:0] CCR_LINREG_CHARGE_HIGH     = 8'h19;
	localparam logic [7:0] CCR_LINREG_CHARGE_LOW      = 8'h1a;
	// ==========================================================
	// widths and reset values
	localparam int          CCR_CNT_W     = 16;        // counter width
	localparam int          CCR_BYTE_W    = 8;         // register width
	localparam int          CCR_PRESC_W   = 3;         // prescaler setting width
	localparam logic [7:0]  CCR_BYTE_RST  = 8'h00;     // reset of every byte register
	localparam logic [15:0] CCR_CNT_RST   = 16'h0000;  // reset of every counter
	localparam logic [7:0]  CCR_UNMAPPED  = 8'h00;     // read data of any other address
	// ==========================================================
	// sync stage count for inputs from outside the mclk domain
	localparam int          CCR_SYNC_N    = 3;
	// input slots in the sync bank
	localparam int          CCR_IN_BUCK   = 0;         // buck pfm pulse
	localparam int          CCR_IN_LDO    = 1;         // linear regulator pfm pulse
	localparam int          CCR_IN_OSC    = 2;         // 10 MHz calibration clock
	localparam int          CCR_IN_N      = 3;
endpackage
`default_nettype wire

// ===== test/ccr_host_model.sv
// host model: reads one counter pair, high byte first, optionally each byte twice
`default_nettype none
module ccr_host_model (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// read request from the bench
	input  wire logic        go,
	input  wire logic        pair,
	input  wire logic        dbl,
	// answer from the block
	input  wire logic        rd_valid,
	input  wire logic [7:0]  rd_data,
	// register port to the block
	output logic      [7:0]  reg_addr,
	output logic             reg_sel,
	output logic             reg_rd,
	// result to the bench
	output logic             done,
	output logic      [15:0] cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       busy;  // a pair read is under way
	logic [2:0] k;     // step: 0 selects only, then reads, then release
	// select a cycle early so suspension is in force at the first read
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			{busy, k, reg_addr, reg_sel, reg_rd, done, cnt} <= '0;
		end else begin
			done <= 1'b0;
			if (rd_valid) begin
				cnt <= {cnt[7:0], rd_data};
			end
			if (!busy) begin
				busy <= go;
				k <= 3'd0;
			end else begin
				k <= k + 3'd1;
				reg_sel <= 1'b1;
				reg_rd <= (k != 3'd0) && (k <= (dbl ? 3'd4 : 3'd2));
				reg_addr <= (pair ? 8'h19 : 8'h17) +
				            ((dbl ? k > 3'd2 : k > 3'd1) ? 8'h01 : 8'h00);
				if (k == (dbl ? 3'd6 : 3'd4)) begin
					// release at once and leave no stale address behind
					{busy, reg_sel, reg_rd} <= '0;
					reg_addr <= ~reg_addr;
					done <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== test/ccr_props.sv
// checker: port timing of the charge counter readout
`default_nettype none
module ccr_props #(
	parameter int CNT_W   = 16,  // counter width
	parameter int PRESC_W = 3    // prescaler setting width
) (
	// clock, reset, enable
	input wire logic       mclk,
	input wire logic       rst_b,
	input wire logic       clk_en,
	// register port
	input wire logic       reg_sel,
	input wire logic       reg_rd,
	input wire logic       rd_valid,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] rd_data,
	// calibration and clear
	input wire logic       calib_active,
	input wire logic       counter_clear_event,
	input wire logic       calib_result_held
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// a read the block takes, and a clear it does not ignore
	wire logic rd_ok  = reg_rd && clk_en;
	wire logic clr_ok = counter_clear_event && clk_en && !calib_active;
	// ==========================================================
	// read port
	a_read_answer: assert property (rd_ok |=> rd_valid)
		else $error("read not answered");
	a_valid_cause: assert property (rd_valid |-> $past(rd_ok))
		else $error("stray valid");
	a_data_holds: assert property (!$past(rd_ok) |-> $stable(rd_data))
		else $error("data moved");
	// ==========================================================
	// suspension and shadow: repeated reads while addressed agree
	a_high_frozen: assert property ($past(reg_sel) && rd_ok && reg_sel && !clr_ok &&
		reg_addr == 8'h17 ##1 rd_ok && reg_sel && reg_addr == 8'h17 |=> $stable(rd_data))
		else $error("high moved");
	a_low_shadow: assert property (rd_ok && reg_addr == 8'h18 ##1 rd_ok &&
		reg_addr == 8'h18 |=> $stable(rd_data))
		else $error("shadow moved");
	// ==========================================================
	// calibration result flag
	a_calib_sets: assert property ($rose(calib_active) && clk_en |=> calib_result_held)
		else $error("held not set");
	a_held_cause: assert property ($rose(calib_result_held) |-> $past(calib_active))
		else $error("held without calibration");
	a_held_keeps: assert property (calib_result_held && !clr_ok |=> calib_result_held)
		else $error("held lost");
	a_held_drops: assert property (calib_result_held && clr_ok |=> !calib_result_held)
		else $error("held kept");
	cover property (rd_ok && reg_addr == 8'h19);
	cover property (rd_ok && reg_addr == 8'h18 ##1 rd_ok && reg_addr == 8'h18);
	cover property ($fell(calib_result_held));
endmodule
`default_nettype wire

// ===== test/testbench.sv
// testbench: counting, prescaling, shadow reads and calibration of the readout
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, rst_b = 0, clk_en = 1, go = 0, pair = 0, dbl = 0, buck_pulse = 0;
	logic linreg_pulse = 0, osc10_clk = 0, deep_sleep_state = 0, linear_regulator_standalone = 0;
	logic calib_active = 0, counter_clear_event = 0, reg_sel, reg_rd, rd_valid;
	logic done, calib_result_held;
	logic [2:0]  counter_prescaler = 0;
	logic [7:0]  reg_addr, rd_data;
	logic [15:0] cnt, v, e;
	int          error_cnt = 0, cmp_count = 0, p, m;
	always #5 mclk = ~mclk;
	ccr_charge_counter_readout i_ccr_charge_counter_readout (.mclk, .rst_b, .clk_en, .reg_addr,
		.reg_sel, .reg_rd, .rd_data, .rd_valid, .buck_pulse, .linreg_pulse, .osc10_clk,
		.deep_sleep_state, .linear_regulator_standalone, .calib_active, .counter_clear_event,
		.counter_prescaler, .calib_result_held);
	ccr_host_model i_ccr_host_model (.mclk, .rst_b, .go, .pair, .dbl, .rd_valid, .rd_data,
		.reg_addr, .reg_sel, .reg_rd, .done, .cnt);
	// ==========================================================
	// expectation, checks and drivers
	function automatic logic [15:0] exp_cnt(input int n, input int ps);
		return 16'(n >> ps);
	endfunction
	task final_report();
		$display("errors %0d, compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk16(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t count %h expected %h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task cyc(input int c);
		repeat (c) @(posedge mclk);
	endtask
	// one pair read through the host model, bounded wait on done
	task rd(input logic pr, input logic d);
		int i;
		pair <= pr;
		dbl <= d;
		go <= 1'b1;
		cyc(1);
		go <= 1'b0;
		for (i = 0; i < 20 && done !== 1'b1; i++) cyc(1);
		if (done !== 1'b1) begin
			error_cnt++;
			$display("ERROR %0t host read timed out", $time);
			final_report();
		end
		v = cnt;
	endtask
	// converter pulses with random spacing, long enough for the sync chain
	task pulses(input logic l, input int n);
		repeat (n) begin
			if (l) linreg_pulse <= 1'b1;
			else buck_pulse <= 1'b1;
			cyc(4 + $urandom_range(3));
			{linreg_pulse, buck_pulse} <= 2'b00;
			cyc(4 + $urandom_range(3));
		end
		cyc(6);
	endtask
	task clear();
		counter_clear_event <= 1'b1;
		cyc(1);
		counter_clear_event <= 1'b0;
		cyc(1);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(32'h6dd57484));
		cyc(5);
		rst_b <= 1'b1;
		cyc(1);
		rd(0, 0);
		chk16(v, 16'h0000);
		rd(1, 0);
		chk16(v, 16'h0000);
		{deep_sleep_state, linear_regulator_standalone} <= 2'b11;
		for (p = 0; p < 3; p++) begin
			counter_prescaler <= p[2:0];
			clear();
			m = $urandom_range(9, 1) << p;
			pulses(0, m);
			pulses(1, m + (1 << p));
			e = exp_cnt(m, p);
			rd(0, 0);
			chk16(v, e);
			rd(1, 0);
			chk16(v, e + 16'h0001);
		end
		// a low clock enable freezes the sync chains, so these pulses are lost
		clk_en <= 1'b0;
		pulses(0, 4);
		clk_en <= 1'b1;
		// no counting outside the mode; doubled reads hit suspension and shadow
		deep_sleep_state <= 1'b0;
		pulses(0, 8);
		rd(0, 1);
		chk16(v, {e[7:0], e[7:0]});
		rd(1, 0);
		chk16(v, e + 16'h0001);
		calib_active <= 1'b1;
		cyc(4);
		m = $urandom_range(60, 20);
		repeat (m) begin
			osc10_clk <= 1'b1;
			cyc(5);
			osc10_clk <= 1'b0;
			cyc(5);
		end
		cyc(6);
		calib_active <= 1'b0;
		cyc(2);
		chk1(calib_result_held, 1'b1);
		pulses(1, 5);
		rd(1, 0);
		chk16(v, 16'(m));
		clear();
		rd(1, 0);
		chk16(v, 16'h0000);
		chk1(calib_result_held, 1'b0);
		final_report();
	end
endmodule
bind ccr_charge_counter_readout ccr_props #(.CNT_W(CNT_W), .PRESC_W(PRESC_W)) i_ccr_props (
	.mclk, .rst_b, .clk_en, .reg_sel, .reg_rd, .rd_valid, .reg_addr, .rd_data,
	.calib_active, .counter_clear_event, .calib_result_held);
`default_nettype wire
